// ### verilog/pfc_top.v
// pause frame flow control: pause send, pause decode, transmit hold-off, avalon registers
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "pfc_map.vh"

module pfc_top (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // client pause request
  input wire pause_req,
  input wire [15:0] pause_val,
  // client transmit handshake
  input wire tx_client_req,
  output reg tx_ack,
  // transmit line state and pause framer
  input wire tx_line_busy,
  output reg tx_pause_valid,
  output reg [47:0] tx_pause_da,
  output reg [47:0] tx_pause_sa,
  output reg [15:0] tx_pause_type,
  output reg [15:0] tx_pause_opcode,
  output reg [15:0] tx_pause_param,
  input wire tx_pause_done,
  // transmit statistics
  output reg tx_stat_valid,
  output reg tx_stat_pause,
  // received frame summary
  input wire rx_frame_end,
  input wire rx_checks_ok,
  input wire [15:0] rx_length,
  input wire [47:0] rx_da,
  input wire [15:0] rx_type,
  input wire [15:0] rx_opcode,
  input wire [15:0] rx_param,
  // receive client marks and statistics
  output reg rx_good_frame,
  output reg rx_bad_frame,
  output reg rx_stat_valid,
  output reg rx_stat_flow
);

  localparam ST_IDLE = 2'b00;
  localparam ST_PAUSE = 2'b01;
  localparam ST_CLIENT = 2'b10;
  localparam integer QCYC_N = `PFC_QUANTUM_CYC;
  localparam [2:0] QCYC_LAST = QCYC_N[2:0] - 3'h1;

  // write the enabled byte lanes into a word
  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0] be;
    integer i;
    begin
      merge_be = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge_be[i*8 +: 8] = wdata[i*8 +: 8];
        end
      end
    end
  endfunction

  // address match against multicast or configured address
  function addr_hit;
    input [47:0] da;
    input [47:0] own;
    begin
      addr_hit = (da == `PFC_MCAST_DA) || (da == own);
    end
  endfunction

  // one-hot register select, shared by the write and read paths
  function [3:0] reg_sel;
    input [3:0] addr;
    begin
      case (addr)
        `PFC_REG_CTRL: reg_sel = 4'h1;
        `PFC_REG_ADDR_LO: reg_sel = 4'h2;
        `PFC_REG_ADDR_HI: reg_sel = 4'h4;
        `PFC_REG_STATUS: reg_sel = 4'h8;
        default: reg_sel = 4'h0;
      endcase
    end
  endfunction

  // register file and bus handshake
  reg [31:0] ctrl;
  reg [47:0] pause_addr;
  reg bus_ack;
  // transmit arbitration
  reg [1:0] tx_state;
  reg pend;
  reg [15:0] pend_val;
  // pause timer and register read data
  reg [15:0] pause_left;
  reg [2:0] quantum_cyc;
  reg [31:0] next_readdata;

  wire tx_en = ctrl[`PFC_CTRL_TX_EN];
  wire rx_en = ctrl[`PFC_CTRL_RX_EN];
  wire paused = (pause_left != 16'h0000);
  wire bus_req = avs_read | avs_write;
  // requests are ignored while pause sending is disabled
  wire take_req = pause_req & tx_en;
  wire rx_is_ctrl = (rx_type == `PFC_CTRL_TYPE);
  wire rx_err_free = rx_checks_ok & (~rx_is_ctrl | (rx_length == `PFC_CTRL_LEN));

  // pause decode of an error-free control frame
  wire rx_da_hit = addr_hit(rx_da, pause_addr);
  wire rx_op_hit = (rx_opcode == `PFC_PAUSE_OP);
  wire rx_act = rx_frame_end & rx_err_free & rx_is_ctrl & rx_en & rx_da_hit & rx_op_hit;
  // receive marks; an acted-on pause goes to the client as failed
  wire next_good = rx_frame_end & rx_err_free & ~rx_act;
  wire next_bad = rx_frame_end & (~rx_err_free | rx_act);
  // client grant is withheld while the pause timer runs
  wire launch = (tx_state == ST_IDLE) & pend & ~tx_line_busy & ~tx_ack;
  wire grant = (tx_state == ST_IDLE) & ~pend & tx_client_req & ~tx_line_busy & ~paused & ~tx_ack;

  // bus decode; a write lands on the edge after the one that ends the wait state
  wire [3:0] sel = reg_sel(avs_address);
  wire wr_commit = avs_write & bus_ack;
  wire rd_take = avs_read & ~bus_ack;
  wire [5:0] lane_we;
  wire [47:0] next_addr;
  // last cycle of a pause unit
  wire quantum_end = (quantum_cyc == QCYC_LAST);

  // one wait state on every access
  // read data are loaded on the first edge and stand through the second
  assign avs_waitrequest = bus_req & ~bus_ack;

  always @(posedge mclk) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  // byte-lane merge of the six pause address bytes
  // the high register only carries bytes four and five
  genvar lane;
  generate
    for (lane = 0; lane < 6; lane = lane + 1) begin : g_addr_lane
      if (lane < 4) begin : g_lo
        assign lane_we[lane] = wr_commit & sel[1] & avs_byteenable[lane];
      end else begin : g_hi
        assign lane_we[lane] = wr_commit & sel[2] & avs_byteenable[lane - 4];
      end
      assign next_addr[lane*8 +: 8] = lane_we[lane] ? avs_writedata[(lane % 4)*8 +: 8] :
                                      pause_addr[lane*8 +: 8];
    end
  endgenerate

  // register writes; status is read-only and only two enable bits are kept
  always @(posedge mclk) begin
    if (!reset_n) begin
      ctrl <= `PFC_CTRL_RESET;
      pause_addr <= `PFC_ADDR_RESET;
    end else begin
      pause_addr <= next_addr;
      if (wr_commit && sel[0]) begin
        ctrl <= merge_be(ctrl, avs_writedata, avs_byteenable) &
                ((32'h1 << `PFC_CTRL_TX_EN) | (32'h1 << `PFC_CTRL_RX_EN));
      end
    end
  end

  // register reads, unmapped reads zero
  always @* begin
    next_readdata = 32'h0000_0000;
    case (sel)
      4'h1: next_readdata = ctrl;
      4'h2: next_readdata = pause_addr[31:0];
      4'h4: next_readdata = {16'h0000, pause_addr[47:32]};
      4'h8: begin
        next_readdata[`PFC_STAT_PAUSED] = paused;
        next_readdata[`PFC_STAT_PENDING] = pend;
        next_readdata[`PFC_STAT_SENDING] = tx_pause_valid;
        next_readdata[`PFC_STAT_LEFT_LSB +: 16] = pause_left;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= next_readdata;
    end
  end

  // pending pause request, latest value kept
  // a request in the launch cycle wins and queues one more frame
  always @(posedge mclk) begin
    if (!reset_n) begin
      pend <= 1'b0;
      pend_val <= 16'h0000;
    end else if (take_req) begin
      pend <= 1'b1;
      pend_val <= pause_val;
    end else if (launch) begin
      pend <= 1'b0;
    end else if (!tx_en) begin
      // disabling the sender drops a request that has not gone out
      pend <= 1'b0;
    end
  end

  // transmit arbiter: pause frame ahead of client frames
  always @(posedge mclk) begin
    if (!reset_n) begin
      tx_state <= ST_IDLE;
      tx_ack <= 1'b0;
      tx_pause_valid <= 1'b0;
      tx_pause_da <= 48'h0000_0000_0000;
      tx_pause_sa <= 48'h0000_0000_0000;
      tx_pause_type <= 16'h0000;
      tx_pause_opcode <= 16'h0000;
      tx_pause_param <= 16'h0000;
      tx_stat_valid <= 1'b0;
      tx_stat_pause <= 1'b0;
    end else begin
      tx_ack <= 1'b0;
      tx_stat_valid <= 1'b0;
      case (tx_state)
        ST_IDLE: begin
          if (launch) begin
            // held-off state does not block this path
            tx_state <= ST_PAUSE;
            tx_pause_valid <= 1'b1;
            tx_pause_da <= `PFC_MCAST_DA;
            tx_pause_sa <= pause_addr;
            tx_pause_type <= `PFC_CTRL_TYPE;
            tx_pause_opcode <= `PFC_PAUSE_OP;
            tx_pause_param <= pend_val;
          end else if (grant) begin
            // client frames of any type pass unchanged
            tx_ack <= 1'b1;
            tx_state <= ST_CLIENT;
          end
        end
        ST_PAUSE: begin
          if (tx_pause_done) begin
            tx_pause_valid <= 1'b0;
            tx_stat_valid <= 1'b1;
            tx_stat_pause <= 1'b1;
            tx_state <= ST_IDLE;
          end
        end
        ST_CLIENT: begin
          // wait for the granted frame to claim the line
          if (tx_line_busy) begin
            tx_state <= ST_IDLE;
          end
        end
        default: begin
          tx_state <= ST_IDLE;
        end
      endcase
      if (grant && !launch) begin
        tx_stat_pause <= 1'b0;
      end
    end
  end

  // receive marking and statistics
  // the statistics flag stays until the next frame end
  always @(posedge mclk) begin
    if (!reset_n) begin
      rx_good_frame <= 1'b0;
      rx_bad_frame <= 1'b0;
      rx_stat_valid <= 1'b0;
      rx_stat_flow <= 1'b0;
    end else begin
      rx_stat_valid <= rx_frame_end;
      rx_good_frame <= next_good;
      rx_bad_frame <= next_bad;
      if (rx_frame_end) begin
        rx_stat_flow <= rx_act;
      end
    end
  end

  // pause timer in units of eight datapath cycles
  // a new pause frame restarts the unit phase as well as the count
  always @(posedge mclk) begin
    if (!reset_n) begin
      pause_left <= 16'h0000;
      quantum_cyc <= 3'h0;
    end else if (rx_act) begin
      pause_left <= rx_param;
      quantum_cyc <= 3'h0;
    end else if (paused) begin
      if (quantum_end) begin
        quantum_cyc <= 3'h0;
        pause_left <= pause_left - 16'h0001;
      end else begin
        quantum_cyc <= quantum_cyc + 3'h1;
      end
    end else begin
      quantum_cyc <= 3'h0;
    end
  end

endmodule

// ### inc/pfc_map.vh
// offsets, fields, reset values and timing counts of the pause flow control block
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

// register byte offsets
`define PFC_REG_CTRL 4'h0
`define PFC_REG_ADDR_LO 4'h4
`define PFC_REG_ADDR_HI 4'h8
`define PFC_REG_STATUS 4'hc

// control fields
`define PFC_CTRL_TX_EN 0
`define PFC_CTRL_RX_EN 5
`define PFC_CTRL_RESET 32'h0000_0000

// status fields
`define PFC_STAT_PAUSED 0
`define PFC_STAT_PENDING 1
`define PFC_STAT_SENDING 2
`define PFC_STAT_LEFT_LSB 16

// pause frame address reset value
`define PFC_ADDR_RESET 48'h0000_0000_0000

// frame constants
`define PFC_MCAST_DA 48'h0180_c200_0001
`define PFC_CTRL_TYPE 16'h8808
`define PFC_PAUSE_OP 16'h0001
`define PFC_CTRL_LEN 16'h0040

// pause quantum timing
`define PFC_QUANTUM_BITS 512
`define PFC_QUANTUM_NS_X10 512
`define PFC_DATAPATH_BITS 64
`define PFC_QUANTUM_CYC (`PFC_QUANTUM_BITS / `PFC_DATAPATH_BITS)

`endif

// ### test/pfc_monitor.sv
// pause flow control port assertions
`timescale 1ns/1ns
module pfc_monitor (
  // clock, reset and receive side
  input logic mclk, reset_n, rx_frame_end, rx_checks_ok, rx_good_frame, rx_bad_frame, rx_stat_valid, rx_stat_flow,
  input logic [15:0] rx_length, rx_type,
  // transmit side
  input logic tx_ack, tx_pause_valid, tx_pause_done, tx_stat_valid, tx_stat_pause,
  input logic [15:0] tx_pause_type, tx_pause_opcode, tx_pause_param,
  input logic [47:0] tx_pause_da
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  rx_answer_a: assert property (rx_frame_end |=> rx_stat_valid && rx_good_frame != rx_bad_frame)
    else $error("no receive answer");
  rx_fail_a: assert property (rx_frame_end && !rx_checks_ok |=> rx_bad_frame && !rx_stat_flow)
    else $error("failed frame not bad");
  ctl_len_a: assert property (rx_frame_end && rx_type == 16'h8808 && rx_length != 16'h0040 |=> rx_bad_frame)
    else $error("odd length control frame not bad");
  flow_bad_a: assert property (rx_stat_valid && rx_stat_flow |-> rx_bad_frame)
    else $error("acted pause not bad");
  pause_fields_a: assert property (tx_pause_valid |->
    tx_pause_da == 48'h0180_c200_0001 && tx_pause_type == 16'h8808 && tx_pause_opcode == 16'h0001)
    else $error("pause fields wrong");
  pause_hold_a: assert property (tx_pause_valid && !tx_pause_done |=> tx_pause_valid && $stable(tx_pause_param))
    else $error("pause frame dropped");
  pause_stat_a: assert property (tx_pause_valid && tx_pause_done |=> tx_stat_valid && tx_stat_pause)
    else $error("pause statistic missing");
  pause_first_a: assert property (tx_pause_valid |-> !tx_ack)
    else $error("grant during pause frame");
endmodule
bind pfc_top pfc_monitor pfc_monitor_inst (.*);

// ### test/pfc_framer_model.sv
// framer stand-in that occupies the line for each granted frame
`timescale 1ns/1ns
module pfc_framer_model (
  input logic mclk, reset_n, slow, tx_ack, tx_pause_valid,
  output logic tx_line_busy, tx_pause_done
);
  logic [7:0] cnt;
  logic is_pause;
  always @(posedge mclk) begin
    tx_pause_done <= 0;
    if (!reset_n) begin
      cnt <= 0;
      tx_line_busy <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt - 8'h01;
      tx_line_busy <= cnt != 8'h01;
      tx_pause_done <= cnt == 8'h01 && is_pause;
    end else if (tx_ack || tx_pause_valid && !tx_pause_done) begin
      cnt <= slow ? 8'h14 : 8'h04;
      tx_line_busy <= 1;
      is_pause <= !tx_ack;
    end
  end
endmodule

// ### test/pfc_top_tb_top.sv
// random and directed bench for pause flow control
`timescale 1ns/1ns
module pfc_top_tb_top;
  localparam logic [47:0] mc_da = 48'h0180_c200_0001, own_sa = 48'h0000_5a5a_12ab;
  logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, pause_req = 0, tx_client_req = 0, rx_frame_end = 0;
  logic rx_checks_ok = 0, slow = 0, en = 1, tx_line_busy, tx_pause_done, tx_ack, tx_pause_valid, avs_waitrequest;
  logic tx_stat_valid, tx_stat_pause, rx_good_frame, rx_bad_frame, rx_stat_valid, rx_stat_flow;
  logic [1:0] ev;
  logic [3:0] avs_address = 0, avs_byteenable = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd, r, seed = 32'h3c;
  logic [15:0] pause_val = 0, rx_length = 0, rx_type = 0, rx_opcode = 0, rx_param = 0;
  logic [15:0] tx_pause_type, tx_pause_opcode, tx_pause_param;
  logic [47:0] rx_da = 0, tx_pause_da, tx_pause_sa;
  integer fails = 0, cmp_count = 0, npv = 0, n0, wn, i;
  pfc_top pfc_top_inst (.*);
  pfc_framer_model pfc_framer_model_inst (.*);
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) if (tx_pause_valid && tx_pause_done) npv <= npv + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [2:0] exp_rx(logic ok, logic [15:0] l, logic [47:0] d, logic [15:0] t, logic [15:0] o);
    logic ef, hit;
    ef = ok && (t != 16'h8808 || l == 16'h0040);
    hit = en && ef && t == 16'h8808 && o == 16'h0001 && (d == mc_da || d == own_sa);
    return {!ef || hit, ef && !hit, hit};
  endfunction
  task chk(input string n, input logic [47:0] e, input logic [47:0] s);
    cmp_count++;
    if (e !== s) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    wn = 0;
    do begin
      @(posedge mclk);
      wn++;
    end while (avs_waitrequest !== 1'b0 && wn < 100);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    chk("bus_wait", 0, wn >= 100);
    @(posedge mclk);
  endtask
  task wait_tx();
    wn = 0;
    do begin
      @(negedge mclk);
      wn++;
    end while (tx_ack !== 1'b1 && tx_pause_valid !== 1'b1 && wn < 300);
    ev = {tx_pause_valid, tx_ack};
    @(posedge mclk);
  endtask
  task rxf(input logic ok, input logic [15:0] l, input logic [47:0] d, input logic [15:0] t, o, p);
    logic [2:0] e;
    e = exp_rx(ok, l, d, t, o);
    {rx_checks_ok, rx_length, rx_da, rx_type, rx_opcode, rx_param, rx_frame_end} <= {ok, l, d, t, o, p, 1'b1};
    @(posedge mclk);
    rx_frame_end <= 0;
    @(negedge mclk);
    chk("rx", e, {rx_bad_frame, rx_good_frame, rx_stat_flow});
    @(posedge mclk);
  endtask
  task hold(input logic [15:0] p, input integer lo, input integer hi);
    rxf(1, 16'h0040, mc_da, 16'h8808, 16'h0001, 16'hffff);
    rxf(1, 16'h0040, own_sa, 16'h8808, 16'h0001, p);
    tx_client_req <= 1;
    wait_tx();
    tx_client_req <= 0;
    chk("hold", 1, wn >= lo && wn <= hi);
    @(posedge mclk);
  endtask
  initial begin
    #3000000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    bus(0, 4'h0, 4'hf, 0);
    chk("ctrl", 0, rd);
    bus(1, 4'h4, 4'hf, 32'h5a5a_1234);
    bus(1, 4'h4, 4'h1, 32'h0000_00ab);
    bus(1, 4'h8, 4'hf, 32'hffff_0000);
    bus(0, 4'h4, 4'hf, 0);
    chk("lo", own_sa[31:0], rd);
    bus(0, 4'h8, 4'hf, 0);
    chk("hi", 0, rd);
    bus(0, 4'h2, 4'hf, 0);
    chk("unmapped", 0, rd);
    for (i = 0; i < 64; i++) begin
      if (i % 16 == 0) begin
        en = i[4];
        bus(1, 4'h0, 4'hf, {26'h0, en, 5'h01});
      end
      r = rnd();
      rxf(r[5] | r[6], r[4] ? 16'h0040 : {8'h0, r[15:8]}, r[1] ? {r, r[15:0]} : (r[0] ? own_sa : mc_da),
        r[2] ? 16'h8808 : r[31:16], r[3] ? 16'h0001 : r[27:12], {8'h0, r[23:16]});
    end
    en = 1;
    bus(1, 4'h0, 4'hf, 32'h21);
    hold(16'h0002, 7, 18);
    hold(16'h0000, 1, 4);
    slow <= 1;
    tx_client_req <= 1;
    wait_tx();
    tx_client_req <= 0;
    n0 = npv;
    pause_req <= 1;
    pause_val <= 16'h1234;
    @(posedge mclk);
    pause_val <= 16'hffff;
    @(posedge mclk);
    pause_req <= 0;
    rxf(1, 16'h0040, mc_da, 16'h8808, 16'h0001, 16'hffff);
    tx_client_req <= 1;
    wait_tx();
    chk("order", 2'b10, ev);
    chk("param", 16'hffff, tx_pause_param);
    chk("sa", own_sa, tx_pause_sa);
    repeat (80) @(posedge mclk);
    chk("count", n0 + 1, npv);
    tx_client_req <= 0;
    rxf(1, 16'h0040, mc_da, 16'h8808, 16'h0001, 16'h0000);
    bus(1, 4'h0, 4'hf, 32'h20);
    n0 = npv;
    pause_req <= 1;
    @(posedge mclk);
    pause_req <= 0;
    repeat (80) @(posedge mclk);
    chk("off", n0, npv);
    tx_client_req <= 1;
    wait_tx();
    tx_client_req <= 0;
    chk("plain", 2'b01, ev);
    end_sim();
  end
endmodule
